/* File: logic/cell_select_pkg.sv */
// Constants and helpers shared by the logic cell input select stage
package cell_select_pkg;

    // ==========================================================
    // Register bus geometry
    // ==========================================================
    localparam int          REG_ADDR_W   = 4;       // Word address width
    localparam int          REG_DATA_W   = 8;       // Register width

    // ==========================================================
    // Register offsets (word index on the plain port)
    // ==========================================================
    localparam logic [3:0]  OFS_SEL34    = 4'h0;    // Data line 3/4 select
    localparam logic [3:0]  OFS_G1TERM   = 4'h1;    // Gate 1 term select
    localparam logic [3:0]  OFS_G1POL    = 4'h2;    // Gate 1 polarity
    localparam logic [3:0]  OFS_STATUS   = 4'h3;    // Live line/gate state

    // ==========================================================
    // Field layout of the data line 3/4 select register
    // ==========================================================
    localparam int          SEL_W        = 3;       // Width of a select code
    localparam int          D4_SEL_LSB   = 4;       // Bits 6..4
    localparam int          D3_SEL_LSB   = 0;       // Bits 2..0
    localparam logic [7:0]  SEL34_MASK   = 8'h77;   // Bits 7 and 3 absent

    // ==========================================================
    // Field layout of the gate 1 term register
    // ==========================================================
    localparam int          T_D4_TRUE    = 7;
    localparam int          T_D4_INV     = 6;
    localparam int          T_D3_TRUE    = 5;
    localparam int          T_D3_INV     = 4;
    localparam int          T_D2_TRUE    = 3;
    localparam int          T_D2_INV     = 2;
    localparam int          T_D1_TRUE    = 1;
    localparam int          T_D1_INV     = 0;

    // Polarity register and status register fields
    localparam int          POL_G1_BIT   = 0;
    localparam int          ST_D3_BIT    = 0;
    localparam int          ST_D4_BIT    = 1;
    localparam int          ST_G1_BIT    = 2;

    // ==========================================================
    // Reset values (the cell wakes with every term excluded)
    // ==========================================================
    localparam logic [7:0]  SEL34_RST    = 8'h00;
    localparam logic [7:0]  G1TERM_RST   = 8'h00;
    localparam logic [7:0]  G1POL_RST    = 8'h00;
    localparam logic [7:0]  RDATA_IDLE   = 8'h00;   // Read data when idle

    // Candidate index bases: code 000 picks base, codes wrap mod 16
    localparam logic [3:0]  D3_BASE      = 4'h8;
    localparam logic [3:0]  D4_BASE      = 4'hC;
    localparam int          CAND_N       = 16;      // Candidate inputs

    // ==========================================================
    // Helpers
    // ==========================================================
    // Map a select code onto a candidate index, wrapping past 15
    function automatic logic [3:0] sel_index(input logic [2:0] code,
                                             input logic [3:0] base);
        sel_index = base + {1'b0, code};
    endfunction : sel_index

    // One data line's contribution: true term, inverted term, or none
    function automatic logic term_pick(input logic take_true,
                                       input logic take_inv,
                                       input logic line);
        term_pick = (take_true & line) | (take_inv & ~line);
    endfunction : term_pick

endpackage : cell_select_pkg

/* File: logic/data_line_mux.sv */
// One data line multiplexer: picks one of eight of the sixteen candidate inputs
`timescale 1ns/1ps
`default_nettype none

module data_line_mux
    import cell_select_pkg::*;
#(
    parameter logic [3:0] BASE = 4'h0       // Candidate picked by code 000
) (
    input  wire logic [CAND_N-1:0] cand,    // Synchronised candidates
    input  wire logic [SEL_W-1:0]  code,    // Select code from register
    output logic                   line     // Chosen candidate
);

    // ==========================================================
    // Selection
    // ==========================================================
    // Pure combinational pick; the owner registers the result
    always_comb begin
        line = cand[sel_index(code, BASE)];
    end

endmodule : data_line_mux

`default_nettype wire

/* File: logic/logic_cell_input_select.sv */
// Logic cell data line 3/4 multiplexers and gate 1 term select stage
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Data 4 code picks candidate 0-3 or 12-15
// - Data 3 codes 011-111 pick candidates 11-15
// - Select register bits 7, 3 read zero
// - Select and term bits read/write, kept
// - Term bits 7/6 gate true/inverted line 4
// - Term bits 5/4 gate true/inverted line 3
// - Term bits 3/2 gate true/inverted line 2
// - Term bits 1/0 gate true/inverted line 1
// - Polarity bit inverts gate 1 output
module logic_cell_input_select
    import cell_select_pkg::*;
#(
    parameter int ADDR_W = REG_ADDR_W,       // Register port address width
    parameter int DATA_W = REG_DATA_W        // Register port data width
) (
    input  wire logic              clk,                   // Core clock
    input  wire logic              sys_rst,               // Async reset
    input  wire logic [ADDR_W-1:0] reg_addr,              // Register index
    input  wire logic [DATA_W-1:0] reg_wdata,             // Write data
    input  wire logic              reg_wr,                // Write strobe
    input  wire logic              reg_rd,                // Read strobe
    output logic      [DATA_W-1:0] reg_rdata,             // Read data
    input  wire logic [CAND_N-1:0] cell_candidate_input,  // Async sources
    input  wire logic              cell_data_line_1,      // From data mux 1
    input  wire logic              cell_data_line_2,      // From data mux 2
    output logic                   cell_data_line_3,      // Chosen line 3
    output logic                   cell_data_line_4,      // Chosen line 4
    output logic                   cell_gate_1            // Gate 1 result
);

    // ==========================================================
    // Declarations
    // ==========================================================
    // Configuration registers
    logic [DATA_W-1:0] sel34_r;          // Data line 3/4 select
    logic [DATA_W-1:0] sel34_nxt;
    logic [DATA_W-1:0] g1term_r;         // Gate 1 term select
    logic [DATA_W-1:0] g1term_nxt;
    logic [DATA_W-1:0] g1pol_r;          // Gate 1 polarity
    logic [DATA_W-1:0] g1pol_nxt;

    // Read path
    logic [DATA_W-1:0] rdata_r;          // Answer, one cycle after strobe
    logic [DATA_W-1:0] rdata_nxt;

    // Candidate synchroniser, two stages
    logic [CAND_N-1:0] cand_meta_r;      // First stage, read by second only
    logic [CAND_N-1:0] cand_sync_r;      // Second stage, safe to use
    logic [CAND_N-1:0] cand_meta_nxt;
    logic [CAND_N-1:0] cand_sync_nxt;

    // Mux results before registering
    logic              d3_pick;          // Line 3 from its multiplexer
    logic              d4_pick;          // Line 4 from its multiplexer

    // Gate 1 evaluation
    logic              g1_or;            // OR of selected terms
    logic              g1_final;         // After polarity

    // Registered outputs
    logic              d3_r;
    logic              d4_r;
    logic              g1_r;
    logic              d3_nxt;
    logic              d4_nxt;
    logic              g1_nxt;

    // Field views of the select register
    logic [SEL_W-1:0]  data3_source_sel;
    logic [SEL_W-1:0]  data4_source_sel;

    // Field views of the gate 1 term register
    logic              g1_take_d4_true;
    logic              g1_take_d4_inverted;
    logic              g1_take_d3_true;
    logic              g1_take_d3_inverted;
    logic              g1_take_d2_true;
    logic              g1_take_d2_inverted;
    logic              g1_take_d1_true;
    logic              g1_take_d1_inverted;
    logic              gate1_output_invert;

    // Address decode
    logic              hit_sel34;
    logic              hit_g1term;
    logic              hit_g1pol;
    logic              hit_status;

    // ==========================================================
    // Address decode
    // ==========================================================
    // Every index bit is compared; wider ports simply compare more
    // Each index is decoded once here so the write and read paths
    // can never disagree about which register a strobe addresses
    always_comb begin
        hit_sel34  = (reg_addr == ADDR_W'(OFS_SEL34));
        hit_g1term = (reg_addr == ADDR_W'(OFS_G1TERM));
        hit_g1pol  = (reg_addr == ADDR_W'(OFS_G1POL));
        hit_status = (reg_addr == ADDR_W'(OFS_STATUS));
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================
    // Writes land on the edge that samples the strobe; others hold
    // A write strobe with an unmapped index leaves every register
    // untouched; nothing signals the refusal back to software
    always_comb begin
        sel34_nxt  = sel34_r;
        g1term_nxt = g1term_r;
        g1pol_nxt  = g1pol_r;
        if (reg_wr && hit_sel34) begin
            // Absent bits are masked so they can never hold a one
            sel34_nxt = reg_wdata & DATA_W'(SEL34_MASK);
        end
        if (reg_wr && hit_g1term) begin
            g1term_nxt = reg_wdata;
        end
        if (reg_wr && hit_g1pol) begin
            // Only the gate 1 polarity bit lives here
            g1pol_nxt = '0;
            g1pol_nxt[POL_G1_BIT] = reg_wdata[POL_G1_BIT];
        end
    end

    // Reset gives a known value; the contents are otherwise kept
    // across everything but this reset
    // Software should still write every register before use, since
    // a real part wakes with undefined configuration
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel34_r  <= DATA_W'(SEL34_RST);
            g1term_r <= DATA_W'(G1TERM_RST);
            g1pol_r  <= DATA_W'(G1POL_RST);
        end else begin
            sel34_r  <= sel34_nxt;
            g1term_r <= g1term_nxt;
            g1pol_r  <= g1pol_nxt;
        end
    end

    // ==========================================================
    // Field views
    // ==========================================================
    // Named slices keep the gate equation readable
    always_comb begin
        data4_source_sel    = sel34_r[D4_SEL_LSB +: SEL_W];
        data3_source_sel    = sel34_r[D3_SEL_LSB +: SEL_W];
        g1_take_d4_true     = g1term_r[T_D4_TRUE];
        g1_take_d4_inverted = g1term_r[T_D4_INV];
        g1_take_d3_true     = g1term_r[T_D3_TRUE];
        g1_take_d3_inverted = g1term_r[T_D3_INV];
        g1_take_d2_true     = g1term_r[T_D2_TRUE];
        g1_take_d2_inverted = g1term_r[T_D2_INV];
        g1_take_d1_true     = g1term_r[T_D1_TRUE];
        g1_take_d1_inverted = g1term_r[T_D1_INV];
        gate1_output_invert = g1pol_r[POL_G1_BIT];
    end

    // ==========================================================
    // Candidate synchroniser
    // ==========================================================
    // Candidates may come from pins or other clocks, so two stages
    // are spent on them; this costs two cycles of input latency
    // Only the second stage feeds the multiplexers, so a metastable
    // first stage never reaches the gate logic
    always_comb begin
        cand_meta_nxt = cell_candidate_input;
        cand_sync_nxt = cand_meta_r;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cand_meta_r <= '0;
            cand_sync_r <= '0;
        end else begin
            cand_meta_r <= cand_meta_nxt;
            cand_sync_r <= cand_sync_nxt;
        end
    end

    // ==========================================================
    // Data line multiplexers
    // ==========================================================
    // Line 4: code 000 starts at candidate 12, wraps to 0 at code 100
    data_line_mux #(
        .BASE (D4_BASE)
    ) u_mux_d4 (
        .cand (cand_sync_r),
        .code (data4_source_sel),
        .line (d4_pick)
    );

    // Line 3: code 000 starts at candidate 8, code 111 reaches 15
    data_line_mux #(
        .BASE (D3_BASE)
    ) u_mux_d3 (
        .cand (cand_sync_r),
        .code (data3_source_sel),
        .line (d3_pick)
    );

    // ==========================================================
    // Gate 1 term select and combine
    // ==========================================================
    // Setting both true and inverted for one line forces a one;
    // that is legal and simply makes the gate constant, high unless the polarity bit is set
    // The picks are used before the output registers so the gate
    // result and the data lines change on the same edge
    always_comb begin
        g1_or = 1'b0;
        g1_or = g1_or | term_pick(g1_take_d4_true,
                                  g1_take_d4_inverted, d4_pick);
        g1_or = g1_or | term_pick(g1_take_d3_true,
                                  g1_take_d3_inverted, d3_pick);
        g1_or = g1_or | term_pick(g1_take_d2_true,
                                  g1_take_d2_inverted,
                                  cell_data_line_2);
        g1_or = g1_or | term_pick(g1_take_d1_true,
                                  g1_take_d1_inverted,
                                  cell_data_line_1);
        // Polarity applies after the OR, before the output register
        g1_final = g1_or ^ gate1_output_invert;
    end

    // ==========================================================
    // Output registers
    // ==========================================================
    // Outputs are registered so downstream logic sees clean levels
    // The register costs one cycle but keeps mux glitches away from
    // whatever consumes the lines and the gate
    always_comb begin
        d3_nxt = d3_pick;
        d4_nxt = d4_pick;
        g1_nxt = g1_final;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            d3_r <= 1'b0;
            d4_r <= 1'b0;
            g1_r <= 1'b0;
        end else begin
            d3_r <= d3_nxt;
            d4_r <= d4_nxt;
            g1_r <= g1_nxt;
        end
    end

    always_comb begin
        cell_data_line_3 = d3_r;
        cell_data_line_4 = d4_r;
        cell_gate_1      = g1_r;
    end

    // ==========================================================
    // Read path
    // ==========================================================
    // Data stand only in the cycle after the strobe, zero otherwise;
    // unmapped indices answer zero
    // The status view shows the registered levels, so it trails the
    // live outputs by one cycle
    always_comb begin
        rdata_nxt = DATA_W'(RDATA_IDLE);
        if (reg_rd) begin
            if (hit_sel34) begin
                rdata_nxt = sel34_r & DATA_W'(SEL34_MASK);
            end else if (hit_g1term) begin
                rdata_nxt = g1term_r;
            end else if (hit_g1pol) begin
                rdata_nxt = g1pol_r;
            end else if (hit_status) begin
                // Live view of the registered lines and gate
                rdata_nxt[ST_D3_BIT] = d3_r;
                rdata_nxt[ST_D4_BIT] = d4_r;
                rdata_nxt[ST_G1_BIT] = g1_r;
            end else begin
                rdata_nxt = DATA_W'(RDATA_IDLE);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= DATA_W'(RDATA_IDLE);
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    always_comb begin
        reg_rdata = rdata_r;
    end

endmodule : logic_cell_input_select

`default_nettype wire

/* File: tb/cell_select_assertions.sv */
// Port checker for the logic cell input select stage
`timescale 1ns/1ps
`default_nettype none

module cell_select_checker
    import cell_select_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [15:0] cell_candidate_input,
    input wire logic        cell_data_line_1,
    input wire logic        cell_data_line_2,
    input wire logic        cell_data_line_3,
    input wire logic        cell_data_line_4,
    input wire logic        cell_gate_1
);
    logic [7:0]  sel_sh;    // Shadow of select register
    logic [7:0]  term_sh;   // Shadow of term register
    logic        pol_sh;    // Shadow of polarity bit
    logic [15:0] c1, c2;    // Candidate sync copy
    logic        e3, e4;    // Expected data lines

    // ==========================================================
    // Shadow state, built from observed bus writes and candidate inputs
    // ==========================================================
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {sel_sh, term_sh, pol_sh, c1, c2, e3, e4} <= '0;
        end else begin
            // Bits 7 and 3 never stick
            if (reg_wr && reg_addr == OFS_SEL34) sel_sh <= reg_wdata & 8'h77;
            if (reg_wr && reg_addr == OFS_G1TERM) term_sh <= reg_wdata;
            if (reg_wr && reg_addr == OFS_G1POL) pol_sh <= reg_wdata[0];
            c1 <= cell_candidate_input;
            c2 <= c1;
            // Line 3 picks 8..15, line 4 picks 12..15 then 0..3
            e3 <= c2[{1'b1, sel_sh[2:0]}];
            e4 <= c2[{{2{~sel_sh[6]}}, sel_sh[5:4]}];
        end
    end

    // OR of the enabled true and inverted terms
    function automatic logic g1(input logic [7:0] t, input logic [3:0] d);
        g1 = |(t & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
    endfunction : g1

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Read strobe on one register
    sequence rd_at(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence

    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    sel_read_a:
        assert property (rd_at(OFS_SEL34) |=> reg_rdata == sel_sh)
        else $error("select readback wrong");
    term_read_a:
        assert property (rd_at(OFS_G1TERM) |=> reg_rdata == term_sh)
        else $error("term readback wrong");
    pol_read_a:
        assert property (rd_at(OFS_G1POL) |=> reg_rdata == {7'h00, pol_sh})
        else $error("polarity readback wrong");
    unmapped_read_a:
        assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    status_read_a:
        assert property (rd_at(OFS_STATUS) |=> reg_rdata == {5'h00,
            $past(cell_gate_1), $past(cell_data_line_4),
            $past(cell_data_line_3)})
        else $error("status readback wrong");
    line3_pick_a: assert property (cell_data_line_3 == e3)
        else $error("line 3 pick wrong");
    line4_pick_a: assert property (cell_data_line_4 == e4)
        else $error("line 4 pick wrong");
    gate_terms_a:
        assert property (cell_gate_1 == ($past(pol_sh) ^ g1($past(term_sh),
            {cell_data_line_4, cell_data_line_3,
             $past(cell_data_line_2), $past(cell_data_line_1)})))
        else $error("gate 1 result wrong");

endmodule : cell_select_checker

bind logic_cell_input_select cell_select_checker chk (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cell_candidate_input(cell_candidate_input),
    .cell_data_line_1(cell_data_line_1), .cell_data_line_2(cell_data_line_2),
    .cell_data_line_3(cell_data_line_3), .cell_data_line_4(cell_data_line_4),
    .cell_gate_1(cell_gate_1));

`default_nettype wire

/* File: tb/logic_cell_input_select_test.sv */
// Self-checking bench for the logic cell input select stage
`timescale 1ns/1ps
`default_nettype none

module logic_cell_input_select_test
    import cell_select_pkg::*;
;
    // One table row: setup and expected {gate, line 4, line 3}
    typedef struct packed {
        logic [7:0]  sel;
        logic [7:0]  term;
        logic        pol;
        logic [15:0] cand;
        logic [1:0]  l21;
        logic [2:0]  exp;
    } row_t;

    logic        clk, sys_rst, reg_wr, reg_rd, l1, l2, was_rd;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [15:0] cand;
    logic        d3, d4, g;
    logic [7:0]  exp_q[$];                 // Pending read answers
    int          mismatches, n_compared;

    // One-hot candidates expose any wrong index; the last two rows use all-zero and one-cold
    row_t rows [14] = '{
        '{8'h00, 8'h20, 1'b0, 16'h0100, 2'b00, 3'b101},
        '{8'h01, 8'h10, 1'b0, 16'h0200, 2'b00, 3'b001},
        '{8'h02, 8'h00, 1'b1, 16'h0400, 2'b00, 3'b101},
        '{8'h03, 8'h00, 1'b0, 16'h0800, 2'b00, 3'b001},
        '{8'h04, 8'h80, 1'b0, 16'h1000, 2'b00, 3'b111},
        '{8'h15, 8'h40, 1'b0, 16'h2000, 2'b00, 3'b011},
        '{8'h26, 8'h00, 1'b1, 16'h4000, 2'b00, 3'b111},
        '{8'h37, 8'h50, 1'b1, 16'h8000, 2'b00, 3'b111},
        '{8'h40, 8'h10, 1'b0, 16'h0001, 2'b00, 3'b110},
        '{8'h50, 8'h02, 1'b0, 16'h0002, 2'b01, 3'b110},
        '{8'h60, 8'h01, 1'b0, 16'h0004, 2'b01, 3'b010},
        '{8'h70, 8'h08, 1'b0, 16'h0008, 2'b10, 3'b110},
        '{8'hFF, 8'h04, 1'b0, 16'h0000, 2'b00, 3'b100},
        '{8'h00, 8'h90, 1'b0, 16'hFEFF, 2'b00, 3'b110}};

    logic_cell_input_select uut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cell_candidate_input(cand),
        .cell_data_line_1(l1), .cell_data_line_2(l2),
        .cell_data_line_3(d3), .cell_data_line_4(d4), .cell_gate_1(g));

    // ==========================================================
    // Clock, checks and verdict
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task end_of_test();
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Read data must stand in the cycle after the strobe, else zero
    always @(posedge clk) begin
        was_rd = reg_rd && !sys_rst;
        #1;
        if (was_rd) check(reg_rdata, exp_q.pop_front());
        else if (!sys_rst) check(reg_rdata, 8'h00);
    end

    // ==========================================================
    // Bus tasks: strobes stay up so calls run back to back
    // ==========================================================
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, d};
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
        exp_q.push_back(e);
    endtask : rd

    task idle(input int n);
        repeat (n) begin
            @(posedge clk);
            {reg_wr, reg_rd} <= 2'b00;
        end
    endtask : idle

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial begin
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 12'h000};
        {cand, l1, l2} = 18'h00000;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        // Table of selections, terms and polarity
        foreach (rows[i]) begin
            wr(OFS_SEL34, rows[i].sel);
            wr(OFS_G1TERM, rows[i].term);
            wr(OFS_G1POL, {7'h00, rows[i].pol});
            cand <= rows[i].cand;
            {l2, l1} <= rows[i].l21;
            idle(4);
            #1 check({7'h00, d3}, 8'(rows[i].exp[0]));
            check({7'h00, d4}, 8'(rows[i].exp[1]));
            check({7'h00, g}, 8'(rows[i].exp[2]));
            rd(OFS_SEL34, rows[i].sel & 8'h77);
            rd(OFS_G1TERM, rows[i].term);
            rd(OFS_G1POL, {7'h00, rows[i].pol});
            rd(OFS_STATUS, {5'h00, rows[i].exp});
        end
        // Candidate reaches line 4 and gate on the third edge
        wr(OFS_SEL34, 8'h00);
        wr(OFS_G1TERM, 8'h80);
        cand <= 16'h0000;
        idle(4);
        @(posedge clk) cand <= 16'h1000;
        for (int k = 1; k <= 3; k++) begin
            @(posedge clk) #1;
            check({6'h00, g, d4}, (k == 3) ? 8'h03 : 8'h00);
        end
        // Line 1 reaches the gate after one edge
        wr(OFS_G1TERM, 8'h02);
        idle(2);
        @(posedge clk) l1 <= 1'b1;
        #1 check({7'h00, g}, 8'h00);
        @(posedge clk) #1;
        check({7'h00, g}, 8'h01);
        // Writes to status and unmapped places change nothing
        for (int a = 3; a < 16; a++) wr(a[3:0], 8'hFF);
        for (int a = 4; a < 16; a++) rd(a[3:0], 8'h00);
        // Upper polarity bits are absent and must read back zero
        wr(OFS_G1POL, 8'hFE);
        rd(OFS_G1POL, 8'h00);
        rd(OFS_SEL34, 8'h00);
        rd(OFS_G1TERM, 8'h02);
        rd(OFS_STATUS, 8'h06);
        idle(2);
        // Second reset clears outputs and registers
        @(posedge clk) sys_rst <= 1'b1;
        idle(3);
        #1 check({5'h00, g, d4, d3}, 8'h00);
        @(posedge clk) sys_rst <= 1'b0;
        rd(OFS_SEL34, 8'h00);
        rd(OFS_G1TERM, 8'h00);
        rd(OFS_G1POL, 8'h00);
        idle(3);
        end_of_test();
    end

endmodule : logic_cell_input_select_test

`default_nettype wire
